/* File: logic/dacs_params.svh */
// constants of the two-channel converter serial control block
// Behaviour
// - control word bits 7:6 and 2:0 have no effect on operation.
// - bits 5:3 form channel address; it applies to the next conversion.
// - address bits 2 and 1 ignored; 00 selects input a (default), 01 input b.
// - result is unsigned straight binary, zero at lowest input voltage.
// - model quantises with step supply/256, first transition at half step.
// - active while chip select low except from 16th falling edge to next first, powered down while high.
// - power down at 16th falling edge, wake at next conversion's first.
// - back-to-back 16-cycle conversions while chip select stays low.
// - control word sampled on first 8 rising edges of each conversion.
// - track 3 cycles, convert 12, asleep 1, result out msb first from 5th clock.
// - serial data out high impedance whenever chip select is high.
`ifndef DACS_PARAMS_SVH
`define DACS_PARAMS_SVH
`define DACS_CONV_CYCLES   5'h10
`define DACS_WORD_BITS     4'h8
`define DACS_TRACK_CYCLES  5'h03
`define DACS_DATA_FIRST    5'h04
`define DACS_DATA_LAST     5'h0B
`define DACS_ADDR_LSB      3
`define DACS_CODE_STEPS    256
`define DACS_CHAN_A        1'h0
`endif

/* File: logic/dacs_pkg.sv */
// types of the two-channel converter serial control block
package dacs_pkg;
    typedef enum logic [1:0] {
        DACS_IDLE  = 2'h0,
        DACS_TRACK = 2'h1,
        DACS_CONV  = 2'h3,
        DACS_SLEEP = 2'h2
    } dacs_state_t;
    typedef struct packed {
        logic       chan;
        logic [7:0] code;
    } dacs_sample_t;
endpackage

/* File: logic/dacs_fifo.sv */
// small valid/ready fifo for result words
`timescale 1ns/100ps
module dacs_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;
    logic [WIDTH-1:0] data_q, data_d;
    logic             valid_q, valid_d;
    always_comb begin
        push    = in_valid_i && (cnt_q != (AW+1)'(DEPTH));
        pop     = out_ready_i && (cnt_q != '0);
        wr_d    = push ? wr_q + 1'b1 : wr_q;
        rd_d    = pop ? rd_q + 1'b1 : rd_q;
        cnt_d   = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        // registered head word, bypassed when it is written this cycle
        valid_d = cnt_d != '0;
        data_d  = (push && wr_q == rd_d) ? in_data_i : mem_q[rd_d];
    end
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q    <= '0;
            rd_q    <= '0;
            cnt_q   <= '0;
            data_q  <= '0;
            valid_q <= 1'h0;
        end else begin
            wr_q    <= wr_d;
            rd_q    <= rd_d;
            cnt_q   <= cnt_d;
            data_q  <= data_d;
            valid_q <= valid_d;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end
    assign in_ready_o  = cnt_q != (AW+1)'(DEPTH);
    assign out_valid_o = valid_q;
    assign out_data_o  = data_q;
endmodule // dacs_fifo

/* File: logic/dacs_core.sv */
// serial control and conversion sequencing of the two-channel converter
`timescale 1ns/100ps
`include "dacs_params.svh"
module dacs_core #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                mclk_i,
    input  wire logic                rst_n_i,
    input  wire logic                cs_n_i,
    input  wire logic                sclk_i,
    input  wire logic                sdi_i,
    output logic                     sdo_o,
    output logic                     sdo_oe_o,
    output logic                     powered_o,
    output logic                     tracking_o,
    output logic                     analog_sel_o,
    input  wire logic [7:0]          conv_code_i,
    input  wire logic                conv_valid_i,
    output logic                     conv_ready_o,
    output dacs_pkg::dacs_sample_t   sample_o,
    output logic                     sample_valid_o,
    input  wire logic                sample_ready_i
);
    import dacs_pkg::*;
    ////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] cs_s_q, clk_s_q, di_s_q;
    logic       clk_last_q;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_s_q     <= 2'h3;
            clk_s_q    <= 2'h0;
            di_s_q     <= 2'h0;
            clk_last_q <= 1'h0;
        end else begin
            cs_s_q     <= {cs_s_q[0], cs_n_i};
            clk_s_q    <= {clk_s_q[0], sclk_i};
            di_s_q     <= {di_s_q[0], sdi_i};
            clk_last_q <= clk_s_q[1];
        end
    end
    logic sel, rise, fall;
    always_comb begin
        sel  = !cs_s_q[1];
        rise = sel && clk_s_q[1] && !clk_last_q;
        fall = sel && !clk_s_q[1] && clk_last_q;
    end
    ////////////////////////////////////////////////////////////////
    // conversion sequencer
    dacs_state_t  st_q, st_d;
    logic [4:0]   cyc_q, cyc_d;
    logic [3:0]   nbit_q, nbit_d;
    logic [7:0]   word_q, word_d;
    logic         chan_q, chan_d, next_q, next_d;
    logic [7:0]   res_q, res_d;
    logic         sdo_q, sdo_d, oe_q, oe_d, pend_q, pend_d;
    logic         pwr_q, pwr_d, trk_q, trk_d, rdy_q, rdy_d;
    dacs_sample_t fin;
    logic         fin_ready, fq_valid;
    always_comb begin
        st_d = st_q; cyc_d = cyc_q; nbit_d = nbit_q; word_d = word_q;
        chan_d = chan_q; next_d = next_q; res_d = res_q; sdo_d = sdo_q;
        pend_d = pend_q;
        // taken by the fifo; a new result below wins
        if (pend_q && fin_ready) begin
            pend_d = 1'h0;
        end
        oe_d = sel;
        if (!sel) begin
            st_d = DACS_IDLE; cyc_d = '0; nbit_d = '0; sdo_d = 1'h0;
        end else begin
            if (fall && st_q != DACS_TRACK && st_q != DACS_CONV) begin
                // first falling edge wakes, next conversion begins
                st_d   = DACS_TRACK;
                cyc_d  = '0;
                nbit_d = '0;
                chan_d = next_q;
                sdo_d  = 1'h0;
            end else if (fall) begin
                cyc_d = cyc_q + 5'h01;
                if (cyc_d == `DACS_TRACK_CYCLES) begin
                    st_d = DACS_CONV;
                    // hold code of the tracked input
                    if (conv_valid_i) begin
                        res_d = conv_code_i;
                    end
                end
                // msb first from the fifth clock, zero elsewhere
                if (cyc_d >= `DACS_DATA_FIRST && cyc_d <= `DACS_DATA_LAST) begin
                    sdo_d = res_q[3'(`DACS_DATA_LAST - cyc_d)];
                end else begin
                    sdo_d = 1'h0;
                end
                // power down on sixteenth falling edge
                if (cyc_d == `DACS_CONV_CYCLES - 5'h01) begin
                    st_d   = DACS_SLEEP;
                    pend_d = 1'h1;
                end
            end
            // first eight rising edges carry the control word
            if (rise && nbit_q < `DACS_WORD_BITS && (st_q == DACS_TRACK || st_q == DACS_CONV)) begin
                word_d = {word_q[6:0], di_s_q[1]};
                nbit_d = nbit_q + 4'h1;
                if (nbit_d == `DACS_WORD_BITS) begin
                    // only word bit 3 (address bit 0) picks the next input
                    next_d = word_d[`DACS_ADDR_LSB];
                end
            end
        end
        // active while selected, asleep between conversions
        pwr_d = sel && st_d != DACS_SLEEP;
        trk_d = st_d == DACS_TRACK;
        rdy_d = !pend_d;
    end
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= DACS_IDLE; cyc_q <= '0; nbit_q <= '0; word_q <= '0;
            chan_q <= `DACS_CHAN_A; next_q <= `DACS_CHAN_A; res_q <= '0;
            sdo_q <= 1'h0; oe_q <= 1'h0; pend_q <= 1'h0;
            pwr_q <= 1'h0; trk_q <= 1'h0; rdy_q <= 1'h1;
        end else begin
            st_q <= st_d; cyc_q <= cyc_d; nbit_q <= nbit_d; word_q <= word_d;
            chan_q <= chan_d; next_q <= next_d; res_q <= res_d;
            sdo_q <= sdo_d; oe_q <= oe_d; pend_q <= pend_d;
            pwr_q <= pwr_d; trk_q <= trk_d; rdy_q <= rdy_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    // straight-binary results queued for the user
    assign fin.chan = chan_q;
    assign fin.code = res_q;
    dacs_fifo #(
        .WIDTH ($bits(dacs_sample_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (fin),
        .in_valid_i  (pend_q),
        .in_ready_o  (fin_ready),
        .out_data_o  (sample_o),
        .out_valid_o (fq_valid),
        .out_ready_i (sample_ready_i)
    );
    assign sample_valid_o = fq_valid;
    assign conv_ready_o   = rdy_q;
    assign sdo_o          = sdo_q;
    assign sdo_oe_o       = oe_q;
    assign analog_sel_o   = chan_q;
    assign powered_o      = pwr_q;
    assign tracking_o     = trk_q;
endmodule // dacs_core

/* File: verif/dacs_asserts.sv */
// pin timing checks of the converter control block
`timescale 1ns/100ps
module dacs_chk (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic sdo_oe_o,
    input wire logic powered_o,
    input wire logic tracking_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_oe_idle_off:
    assert property (cs_n_i [*4] |-> !sdo_oe_o) else $error("oe while idle");
    a_oe_sel_on:
    assert property (!cs_n_i [*4] |-> sdo_oe_o) else $error("no oe");
    a_oe_rise_cause:
    assert property ($rose(sdo_oe_o) |-> !$past(cs_n_i, 2)) else $error("early oe");
    a_idle_power_off:
    assert property (cs_n_i [*4] |-> !powered_o) else $error("power while idle");
    a_idle_no_track:
    assert property (cs_n_i [*4] |-> !tracking_o) else $error("track while idle");
    a_track_powered:
    assert property (tracking_o |-> powered_o) else $error("track unpowered");
    a_track_len:
    assert property ($rose(tracking_o) |-> ##[30:45] $fell(tracking_o)) else $error("track length");
    a_conv_sleep:
    assert property ($fell(tracking_o) && powered_o |-> ##[144:156] $fell(powered_o)) else $error("sleep late");
endmodule // dacs_chk
bind dacs_core dacs_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sdo_oe_o(sdo_oe_o),
    .powered_o(powered_o), .tracking_o(tracking_o));

/* File: verif/dacs_master.sv */
// serial master model of the converter pins
`timescale 1ns/100ps
module dacs_master (
    output logic     cs_n_o,
    output logic     sclk_o,
    output logic     sdi_o,
    input wire logic sdo_i
);
    initial begin
        cs_n_o = 1'h1;
        sclk_o = 1'h1;
        sdi_o = 1'h0;
    end
    task automatic conv(input logic [7:0] w, input logic first, input logic last, output logic [15:0] r);
        if (first) begin
            cs_n_o = 1'h0;
            #62.5;
        end
        for (int i = 0; i < 16; i++) begin
            sclk_o = 1'h0;
            sdi_o = (i < 8) ? w[7-i] : ~sdi_o;
            #62.5;
            sclk_o = 1'h1;
            r[15-i] = sdo_i;
            #62.5;
        end
        if (last) begin
            cs_n_o = 1'h1;
            #500;
        end
    endtask
endmodule // dacs_master

/* File: verif/tb.sv */
// self-checking bench of the converter control block
`timescale 1ns/100ps
module tb;
    import dacs_pkg::*;
    logic         mclk_i, rst_n_i, cs_n_i, sclk_i, sdi_i, sdo_o, sdo_oe_o, sel, valid, ready, nxt, rdy;
    dacs_sample_t smp;
    dacs_sample_t exp_q[$];
    int           err_total, checks, mv_a, mv_b;
    wire          sdo_w = sdo_oe_o ? sdo_o : 1'bz;
    function automatic logic [7:0] quant(int mv);
        return 8'((mv * 512 / 3300 + 1) / 2);
    endfunction
    dacs_core uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i), .sdi_i(sdi_i),
        .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .powered_o(), .tracking_o(), .analog_sel_o(sel),
        .conv_code_i(quant(sel ? mv_b : mv_a)), .conv_valid_i(1'h1), .conv_ready_o(rdy), .sample_o(smp),
        .sample_valid_o(valid), .sample_ready_i(ready));
    dacs_master m (.cs_n_o(cs_n_i), .sclk_o(sclk_i), .sdi_o(sdi_i), .sdo_i(sdo_w));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic frame(input logic [7:0] w[]);
        logic [15:0] r;
        logic [7:0]  c;
        foreach (w[k]) begin
            c = quant(nxt ? mv_b : mv_a);
            exp_q.push_back({nxt, c});
            m.conv(w[k], k == 0, k == w.size() - 1, r);
            chk(r, {4'h0, c, 4'h0});
            chk({14'h0, sel, rdy}, {14'h0, nxt, 1'h1});
            nxt = w[k][3];
        end
        chk({15'h0, sdo_w}, {15'h0, 1'hZ});
        $display("frame of %0d done", w.size());
    endtask
    task automatic drain;
        int n;
        n = 0;
        while (exp_q.size() > 0 && n < 200) begin
            @(negedge mclk_i);
            n++;
            if (valid === 1'h1)
                chk({7'h0, smp}, {7'h0, exp_q.pop_front()});
            ready = 1'h1;
        end
        repeat (4) @(negedge mclk_i);
        chk({15'h0, valid}, 16'h0000);
        chk(16'(exp_q.size()), 16'h0000);
        $display("drain done");
    endtask
    initial begin
        mclk_i = 1'h0;
        forever #5 mclk_i = ~mclk_i;
    end
    initial begin
        rst_n_i = 1'h0;
        ready = 1'h0;
        nxt = 1'h0;
        mv_a = 1000;
        mv_b = 2000;
        err_total = 0;
        checks = 0;
        repeat (10) @(negedge mclk_i);
        rst_n_i = 1'h1;
        repeat (3) @(negedge mclk_i);
        chk({8'h00, quant(6)}, 16'h0000);
        chk({8'h00, quant(7)}, 16'h0001);
        chk({8'h00, quant(1000)}, 16'h004E);
        frame('{8'h08, 8'hE7, 8'hEF, 8'h00, 8'h08});
        mv_a = 7;
        frame('{8'hC7, 8'h2F, 8'h00});
        drain();
        close_out();
    end
endmodule // tb
